//--- i2cc_defs.svh
// Offsets, field positions, reset values and sync depth of the bus control block
`ifndef I2CC_DEFS_SVH
`define I2CC_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define I2CC_BUS_CONTROL_ADDR 16'hFFA6
`define I2CC_BUS_CONTROL_RST  8'h00

// ----------------------------------------
// Field positions of bus_control
// ----------------------------------------
`define I2CC_IFACE_EN_BIT  3'h7
`define I2CC_EXIT_BIT      3'h6
`define I2CC_WCANCEL_BIT   3'h5
`define I2CC_SPIE_BIT      3'h4
`define I2CC_WTIM_BIT      3'h3
`define I2CC_ACKE_BIT      3'h2
`define I2CC_STOP_TRG_BIT  3'h1
`define I2CC_START_TRG_BIT 3'h0

// ----------------------------------------
// Bit counting on the serial clock, and line synchroniser depth
// ----------------------------------------
`define I2CC_CNT_EIGHTH 4'h8
`define I2CC_CNT_NINTH  4'h9
`define I2CC_SYNC_DEPTH 2

`endif

//--- i2cc_pkg.sv
// Types shared by the bus control block
package i2cc_pkg;

	// Control register, bit 7 first
	typedef struct packed {
		logic interface_enable;
		logic exit_communication;
		logic wait_cancel;
		logic stop_interrupt_enable;
		logic wait_timing_select;
		logic acknowledge_enable;
		logic stop_trigger;
		logic start_trigger;
	} i2cc_ctrl_t;

	// Status and flag bits held by the block
	typedef struct packed {
		logic master_state_flag;
		logic extension_code_flag;
		logic address_match_flag;
		logic transmit_direction_flag;
		logic acknowledge_seen_flag;
		logic start_seen_flag;
		logic start_refused_flag;
		logic bus_busy_flag;
		logic clock_line_level;
		logic data_line_level;
	} i2cc_flags_t;

	// Sampled line events
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} i2cc_line_t;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_IDLE,
		ST_XFER,
		ST_WAIT,
		ST_STANDBY
	} i2cc_state_t;

endpackage : i2cc_pkg

//--- i2cc_line_mon.sv
// Line synchroniser and start/stop/edge detector for the two bus lines
`timescale 1ns/1ps
`default_nettype none
`include "i2cc_defs.svh"

module i2cc_line_mon (
	input  wire logic              clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output var  i2cc_pkg::i2cc_line_t line_out
);

	// ----------------------------------------
	// Two-stage synchronisers, then one history stage
	// ----------------------------------------
	logic [1:0] raw;
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] hist_q;

	assign raw = {scl_in, sda_in};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			// Idle bus reads high, so stages reset high to avoid a false edge
			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					meta_q[g] <= 1'b1;
					sync_q[g] <= 1'b1;
					hist_q[g] <= 1'b1;
				end else begin
					meta_q[g] <= raw[g];
					sync_q[g] <= meta_q[g];
					hist_q[g] <= sync_q[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Events from the settled stages only
	// ----------------------------------------
	always_comb begin
		line_out.scl      = sync_q[1];
		line_out.sda      = sync_q[0];
		line_out.scl_rise = sync_q[1] & ~hist_q[1];
		line_out.scl_fall = ~sync_q[1] & hist_q[1];
		line_out.start    = sync_q[1] & hist_q[1] & ~sync_q[0] & hist_q[0];
		line_out.stop     = sync_q[1] & hist_q[1] & sync_q[0] & ~hist_q[0];
	end

endmodule : i2cc_line_mon
`default_nettype wire

//--- i2cc_bus_control.sv
// Control register and wait/standby logic of the two-wire serial interface
//
// Behaviour
// - Those three bits are taken in the same write that enables the interface.
// - Reset clears the whole control register to zero.
// - Register at FFA6H: enable, exit, cancel, stop-irq, timing, ack, stop, start.
// - Register takes single-bit and whole-byte writes.
// - Enable low halts the bus engine and holds status at reset values.
// - Disable also clears start-refused, bus-busy and both line-level monitors.
// - Writing exit abandons the transfer and enters standby.
// - Exit bit clears itself once performed.
// - Exit floats both lines and clears triggers and transfer status flags.
// - Standby ends on stop then master restart, or match/extension after start.
// - Wait-cancel releases the wait, then clears itself.
// - Cancel at ninth-clock wait while transmitting floats data, direction to receive.
// - Exit, wait-cancel and the start/stop triggers are ignored while disabled.
// - Enabling with clock high and data low detects a start at once.
// - Stop detection raises the interrupt only if stop-irq enable is set.
// - Timing bit picks eighth or ninth falling edge for interrupt and wait on data bytes.
// - With ack enabled, data is driven low in the ninth clock of received data bytes.
`timescale 1ns/1ps
`default_nettype none
`include "i2cc_defs.svh"

module i2cc_bus_control (
	input  wire logic                  clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic [15:0]           cpu_addr_in,
	input  wire logic                  cpu_wr_in,
	input  wire logic                  cpu_bit_wr_in,
	input  wire logic [2:0]            cpu_bit_sel_in,
	input  wire logic [7:0]            cpu_wdata_in,
	input  wire logic                  cpu_rd_in,
	output var  logic [7:0]            cpu_rdata_out,
	input  wire logic                  shift_write_in,
	input  wire logic                  tx_bit_in,
	input  wire logic                  tx_dir_in,
	input  wire logic                  addr_match_in,
	input  wire logic                  ext_code_in,
	input  wire logic                  serial_clock_line_in,
	output var  logic                  serial_clock_line_out,
	output var  logic                  serial_clock_line_oe_out,
	input  wire logic                  serial_data_line_in,
	output var  logic                  serial_data_line_out,
	output var  logic                  serial_data_line_oe_out,
	output var  logic                  bus_interrupt_request_out,
	output var  i2cc_pkg::i2cc_ctrl_t  bus_control_out,
	output var  i2cc_pkg::i2cc_flags_t flags_out
);

	// ----------------------------------------
	// Line monitor
	// ----------------------------------------
	i2cc_pkg::i2cc_line_t line;

	i2cc_line_mon u_line_mon (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.scl_in   (serial_clock_line_in),
		.sda_in   (serial_data_line_in),
		.line_out (line)
	);

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	i2cc_pkg::i2cc_ctrl_t ctrl_q;
	i2cc_pkg::i2cc_ctrl_t ctrl_d;
	i2cc_pkg::i2cc_ctrl_t wval;
	logic                 hit;
	logic                 en;
	logic                 wait_release;

	assign en = ctrl_q.interface_enable;
	assign hit = (cpu_addr_in == `I2CC_BUS_CONTROL_ADDR) & (cpu_wr_in | cpu_bit_wr_in);

	always_comb begin
		wval = ctrl_q;
		if (cpu_wr_in) begin
			wval = i2cc_pkg::i2cc_ctrl_t'(cpu_wdata_in);
		end else begin
			wval[cpu_bit_sel_in] = cpu_wdata_in[0];
		end
	end

	always_comb begin
		ctrl_d = ctrl_q;
		// Self-clearing bits drop the cycle after they act
		if (ctrl_q.exit_communication) begin
			ctrl_d.exit_communication = 1'b0;
			ctrl_d.start_trigger      = 1'b0;
			ctrl_d.stop_trigger       = 1'b0;
		end
		if (ctrl_q.wait_cancel) begin
			ctrl_d.wait_cancel = 1'b0;
		end
		if (line.start) begin
			ctrl_d.start_trigger = 1'b0;
		end
		if (line.stop) begin
			ctrl_d.stop_trigger = 1'b0;
		end
		if (hit) begin
			// Config bits stored on every write, so enabling write carries them
			ctrl_d.interface_enable      = wval.interface_enable;
			ctrl_d.stop_interrupt_enable = wval.stop_interrupt_enable;
			ctrl_d.wait_timing_select    = wval.wait_timing_select;
			ctrl_d.acknowledge_enable    = wval.acknowledge_enable;
			if (en) begin
				// Strobe bits only act on an enabled interface
				ctrl_d.exit_communication = wval.exit_communication;
				ctrl_d.wait_cancel        = wval.wait_cancel;
				ctrl_d.start_trigger      = wval.start_trigger;
				ctrl_d.stop_trigger       = wval.stop_trigger;
			end
		end
		if (!ctrl_d.interface_enable) begin
			ctrl_d.exit_communication = 1'b0;
			ctrl_d.wait_cancel        = 1'b0;
			ctrl_d.start_trigger      = 1'b0;
			ctrl_d.stop_trigger       = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_q <= i2cc_pkg::i2cc_ctrl_t'(`I2CC_BUS_CONTROL_RST);
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ----------------------------------------
	// Bus engine state
	// ----------------------------------------
	i2cc_pkg::i2cc_state_t st_q;
	i2cc_pkg::i2cc_state_t st_d;
	i2cc_pkg::i2cc_flags_t fl_q;
	i2cc_pkg::i2cc_flags_t fl_d;
	logic [3:0]            cnt_q;
	logic [3:0]            cnt_d;
	logic                  addr_ph_q;
	logic                  addr_ph_d;
	logic                  ninth_q;
	logic                  ninth_d;
	logic                  en_prev_q;
	logic                  stop_seen_q;
	logic                  stop_seen_d;
	logic                  irq_d;
	logic                  start_evt;
	logic                  spie_on;

	// Enabling onto a low data line counts as a start
	assign start_evt = line.start | (en & ~en_prev_q & line.scl & ~line.sda);
	assign spie_on = ctrl_q.stop_interrupt_enable & en;
	assign wait_release = ctrl_q.wait_cancel | shift_write_in;

	always_comb begin
		st_d        = st_q;
		fl_d        = fl_q;
		cnt_d       = cnt_q;
		addr_ph_d   = addr_ph_q;
		ninth_d     = ninth_q;
		stop_seen_d = stop_seen_q;
		irq_d       = 1'b0;
		fl_d.clock_line_level = line.scl;
		fl_d.data_line_level  = line.sda;
		unique case (st_q)
			i2cc_pkg::ST_OFF: begin
				st_d = i2cc_pkg::ST_IDLE;
			end
			i2cc_pkg::ST_IDLE: begin
				if (start_evt) begin
					st_d      = i2cc_pkg::ST_XFER;
					cnt_d     = 4'hF; // Start's own clock fall wraps this to zero
					addr_ph_d = 1'b1;
				end
			end
			i2cc_pkg::ST_XFER: begin
				if (line.scl_rise && cnt_q == `I2CC_CNT_EIGHTH) begin
					fl_d.acknowledge_seen_flag = ~line.sda;
				end
				if (line.scl_fall) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q + 4'h1 == `I2CC_CNT_EIGHTH && !ctrl_q.wait_timing_select && !addr_ph_q) begin
						st_d    = i2cc_pkg::ST_WAIT;
						ninth_d = 1'b0;
						irq_d   = 1'b1;
					end else if (cnt_q + 4'h1 == `I2CC_CNT_NINTH) begin
						cnt_d     = 4'h0;
						addr_ph_d = 1'b0;
						if (addr_ph_q) begin
							fl_d.transmit_direction_flag = tx_dir_in;
							fl_d.address_match_flag      = addr_match_in;
							fl_d.extension_code_flag     = ext_code_in;
						end
						// Address bytes always wait at the ninth edge
						if (ctrl_q.wait_timing_select || addr_ph_q) begin
							st_d    = i2cc_pkg::ST_WAIT;
							ninth_d = 1'b1;
							irq_d   = 1'b1;
						end
					end
				end
			end
			i2cc_pkg::ST_WAIT: begin
				if (wait_release) begin
					st_d = i2cc_pkg::ST_XFER;
					if (ninth_q && fl_q.transmit_direction_flag && ctrl_q.wait_cancel) begin
						fl_d.transmit_direction_flag = 1'b0;
					end
				end
			end
			i2cc_pkg::ST_STANDBY: begin
				// Only a match or extension after a start, or a restart, re-engages
				if (fl_q.start_seen_flag && (addr_match_in || ext_code_in)) begin
					st_d                     = i2cc_pkg::ST_XFER;
					cnt_d                    = 4'hF; // Engaged before the start's clock fall
					addr_ph_d                = 1'b0;
					fl_d.address_match_flag  = addr_match_in;
					fl_d.extension_code_flag = ext_code_in;
				end else if (stop_seen_q && ctrl_q.start_trigger) begin
					st_d = i2cc_pkg::ST_IDLE;
				end
			end
		endcase
		if (start_evt) begin
			fl_d.start_seen_flag = 1'b1;
			fl_d.bus_busy_flag   = 1'b1;
			stop_seen_d          = 1'b0;
		end
		if (line.stop) begin
			fl_d.bus_busy_flag     = 1'b0;
			fl_d.master_state_flag = 1'b0;
			fl_d.start_seen_flag   = 1'b0;
			stop_seen_d            = 1'b1;
			irq_d                  = irq_d | spie_on;
			if (st_q != i2cc_pkg::ST_STANDBY) begin
				st_d = i2cc_pkg::ST_IDLE;
			end
		end
		// Start request: refused while the bus is taken; set wins over a stop's clear, exit still clears it
		if (hit && en && wval.start_trigger) begin
			if (fl_q.bus_busy_flag) begin
				fl_d.start_refused_flag = 1'b1;
			end else begin
				fl_d.master_state_flag = 1'b1;
			end
		end
		if (ctrl_q.exit_communication) begin
			st_d                         = i2cc_pkg::ST_STANDBY;
			fl_d.master_state_flag       = 1'b0;
			fl_d.extension_code_flag     = 1'b0;
			fl_d.address_match_flag      = 1'b0;
			fl_d.transmit_direction_flag = 1'b0;
			fl_d.acknowledge_seen_flag   = 1'b0;
			fl_d.start_seen_flag         = 1'b0;
			stop_seen_d                  = 1'b0;
		end
		if (!en) begin
			st_d        = i2cc_pkg::ST_OFF;
			fl_d        = '0;
			cnt_d       = 4'h0;
			addr_ph_d   = 1'b0;
			ninth_d     = 1'b0;
			stop_seen_d = 1'b0;
			irq_d       = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q        <= i2cc_pkg::ST_OFF;
			fl_q        <= '0;
			cnt_q       <= 4'h0;
			addr_ph_q   <= 1'b0;
			ninth_q     <= 1'b0;
			en_prev_q   <= 1'b0;
			stop_seen_q <= 1'b0;
		end else begin
			st_q        <= st_d;
			fl_q        <= fl_d;
			cnt_q       <= cnt_d;
			addr_ph_q   <= addr_ph_d;
			ninth_q     <= ninth_d;
			en_prev_q   <= en;
			stop_seen_q <= stop_seen_d;
		end
	end

	// ----------------------------------------
	// Pin drive and read port
	// ----------------------------------------
	logic       scl_oe_d;
	logic       sda_oe_d;
	logic       scl_oe_q;
	logic       sda_oe_q;
	logic       irq_q;
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic       in_xfer;

	// Both pins float in standby and while off
	assign in_xfer = (st_d == i2cc_pkg::ST_XFER) | (st_d == i2cc_pkg::ST_WAIT);

	always_comb begin
		scl_oe_d = (st_d == i2cc_pkg::ST_WAIT);
		sda_oe_d = 1'b0;
		if (in_xfer && cnt_d == `I2CC_CNT_EIGHTH && !fl_d.transmit_direction_flag) begin
			// Address ack comes from the match; data ack from the enable
			sda_oe_d = addr_ph_d ? addr_match_in : ctrl_q.acknowledge_enable;
		end else if (in_xfer && cnt_d < `I2CC_CNT_EIGHTH && fl_d.transmit_direction_flag) begin
			sda_oe_d = ~tx_bit_in;
		end
		rdata_d = rdata_q;
		if (cpu_rd_in) begin
			rdata_d = (cpu_addr_in == `I2CC_BUS_CONTROL_ADDR) ? ctrl_q : 8'h00;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			irq_q    <= 1'b0;
			rdata_q  <= 8'h00;
		end else begin
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
			irq_q    <= irq_d;
			rdata_q  <= rdata_d;
		end
	end

	// Open drain: only ever pull low
	assign serial_clock_line_out     = 1'b0;
	assign serial_data_line_out      = 1'b0;
	assign serial_clock_line_oe_out  = scl_oe_q;
	assign serial_data_line_oe_out   = sda_oe_q;
	assign bus_interrupt_request_out = irq_q;
	assign bus_control_out           = ctrl_q;
	assign flags_out                 = fl_q;
	assign cpu_rdata_out             = rdata_q;

endmodule : i2cc_bus_control
`default_nettype wire

//--- i2cc_bus_control_properties.sv
// Port-level checks of the bus control block
`timescale 1ns/1ps
`default_nettype none
`include "i2cc_defs.svh"

module i2cc_bus_control_checker (
	input wire logic                  clk_in,
	input wire logic                  rst_n_in,
	input wire logic [15:0]           cpu_addr_in,
	input wire logic                  cpu_wr_in,
	input wire logic                  cpu_bit_wr_in,
	input wire logic [7:0]            cpu_wdata_in,
	input wire logic                  shift_write_in,
	input wire logic                  serial_clock_line_oe_out,
	input wire logic                  serial_data_line_oe_out,
	input wire i2cc_pkg::i2cc_ctrl_t  bus_control_out,
	input wire i2cc_pkg::i2cc_flags_t flags_out
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic sel;
	logic en;
	logic ex;
	logic wc;
	assign sel = (cpu_addr_in == `I2CC_BUS_CONTROL_ADDR);
	assign en  = bus_control_out.interface_enable;
	assign ex  = bus_control_out.exit_communication;
	assign wc  = bus_control_out.wait_cancel;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_exit_self_clear: assert property (ex |=> !ex)
		else $error("exit bit stuck");
	a_cancel_self_clear: assert property (wc |=> !wc)
		else $error("cancel bit stuck");
	a_exit_floats_lines: assert property (ex |=> !serial_clock_line_oe_out && !serial_data_line_oe_out)
		else $error("lines held after exit");
	a_off_ignores: assert property (!en |-> !(ex || wc || bus_control_out[1:0] != 2'h0))
		else $error("control taken while off");
	a_off_status: assert property (!en && !$past(en) |-> flags_out == 10'h000 && !serial_clock_line_oe_out)
		else $error("status live while off");
	a_config_taken: assert property (cpu_wr_in && sel |=> bus_control_out[4:2] == $past(cpu_wdata_in[4:2]))
		else $error("config bits lost");
	a_enable_write: assert property (cpu_wr_in && sel |=> en == $past(cpu_wdata_in[7]))
		else $error("enable not written");
	a_wait_holds: assert property (serial_clock_line_oe_out && en && !ex && !wc && !shift_write_in
		&& !cpu_wr_in && !cpu_bit_wr_in |=> serial_clock_line_oe_out)
		else $error("wait dropped early");

	c_wait: cover property ($rose(serial_clock_line_oe_out));
	c_exit: cover property (ex && flags_out.master_state_flag == 1'b0);
	c_cancel: cover property (wc ##2 !serial_clock_line_oe_out);
endmodule : i2cc_bus_control_checker

bind i2cc_bus_control i2cc_bus_control_checker u_i2cc_bus_control_checker (
	.clk_in, .rst_n_in, .cpu_addr_in, .cpu_wr_in, .cpu_bit_wr_in, .cpu_wdata_in, .shift_write_in,
	.serial_clock_line_oe_out, .serial_data_line_oe_out, .bus_control_out, .flags_out
);
`default_nettype wire

//--- i2cc_bus_model.sv
// Other master on the two-wire bus, open drain with pull-ups
`timescale 1ns/1ps
`default_nettype none

module i2cc_bus_model (
	input  wire logic dut_scl_oe_in,
	input  wire logic dut_sda_oe_in,
	output wire logic scl_out,
	output wire logic sda_out
);
	// ----------------------------------------
	// Wired-AND lines, clock idle high between frames
	// ----------------------------------------
	logic scl_oe = 1'b0;
	logic sda_oe = 1'b0;
	assign scl_out = !(scl_oe || dut_scl_oe_in);
	assign sda_out = !(sda_oe || dut_sda_oe_in);

	// Bounded so a stuck wait cannot hang the run
	task automatic clk_high();
		int k;
		k = 0;
		scl_oe = 1'b0;
		while (!scl_out && k < 4000) begin
			#1;
			k++;
		end
		#32;
	endtask : clk_high

	task automatic set_data(input logic low);
		sda_oe = low;
	endtask : set_data

	task automatic start_cond();
		sda_oe = 1'b0;
		#16;
		clk_high();
		sda_oe = 1'b1;
		#32;
		scl_oe = 1'b1;
		#16;
	endtask : start_cond

	task automatic stop_cond();
		scl_oe = 1'b1;
		sda_oe = 1'b1;
		#16;
		clk_high();
		sda_oe = 1'b0;
		#32;
	endtask : stop_cond

	// Ninth clock leaves data released for the acknowledge
	task automatic send_byte(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			sda_oe = (i > 0) ? !b[i - 1] : 1'b0;
			#16;
			clk_high();
			scl_oe = 1'b1;
			#16;
		end
	endtask : send_byte
endmodule : i2cc_bus_model
`default_nettype wire

//--- i2cc_bus_control_tb_top.sv
// Self-checking bench for the bus control block
`timescale 1ns/1ps
`default_nettype none
`include "i2cc_defs.svh"

module i2cc_bus_control_tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [15:0] CTRL = `I2CC_BUS_CONTROL_ADDR;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [15:0] cpu_addr_in = 16'h0000;
	logic cpu_wr_in = 1'b0;
	logic cpu_bit_wr_in = 1'b0;
	logic [2:0] cpu_bit_sel_in = 3'h0;
	logic [7:0] cpu_wdata_in = 8'h00;
	logic cpu_rd_in = 1'b0;
	logic [7:0] cpu_rdata_out;
	logic addr_match_in = 1'b0;
	logic shift_write_in = 1'b0;
	logic tx_bit_in = 1'b1;
	logic tx_dir_in = 1'b0;
	logic ext_code_in = 1'b0;
	logic scl_o, sda_o;
	logic scl, sda, scl_oe, sda_oe, irq;
	i2cc_pkg::i2cc_ctrl_t ctrl;
	i2cc_pkg::i2cc_flags_t flags_out;
	int n_errors = 0;
	int n_compared = 0;
	int n_irq = 0;
	int k;

	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) if (irq === 1'b1) n_irq <= n_irq + 1;

	i2cc_bus_control u_i2cc_bus_control (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .cpu_addr_in(cpu_addr_in), .cpu_wr_in(cpu_wr_in),
		.cpu_bit_wr_in(cpu_bit_wr_in), .cpu_bit_sel_in(cpu_bit_sel_in), .cpu_wdata_in(cpu_wdata_in),
		.cpu_rd_in(cpu_rd_in), .cpu_rdata_out(cpu_rdata_out), .shift_write_in(shift_write_in),
		.tx_bit_in(tx_bit_in), .tx_dir_in(tx_dir_in), .addr_match_in(addr_match_in),
		.ext_code_in(ext_code_in), .serial_clock_line_in(scl),
		.serial_clock_line_out(scl_o), .serial_clock_line_oe_out(scl_oe), .serial_data_line_in(sda),
		.serial_data_line_out(sda_o), .serial_data_line_oe_out(sda_oe), .bus_interrupt_request_out(irq),
		.bus_control_out(ctrl), .flags_out(flags_out));

	i2cc_bus_model u_i2cc_bus_model (
		.dut_scl_oe_in(scl_oe), .dut_sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : cyc

	task automatic wr(input logic bitw, input logic [2:0] s, input logic [7:0] d);
		cyc(1);
		cpu_addr_in = CTRL;
		cpu_bit_sel_in = s;
		cpu_wdata_in = d;
		cpu_wr_in = !bitw;
		cpu_bit_wr_in = bitw;
		cyc(1);
		cpu_wr_in = 1'b0;
		cpu_bit_wr_in = 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		cyc(1);
		cpu_addr_in = a;
		cpu_rd_in = 1'b1;
		cyc(1);
		cpu_rd_in = 1'b0;
		chk(cpu_rdata_out, exp);
	endtask : rd

	task automatic stop_test();
		if (n_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		cyc(6);
		rst_n_in = 1'b1;
		rd(CTRL, 8'h00);
		rd(16'hFFA7, 8'h00);
		chk({scl_o, sda_o}, 2'h0);
		wr(0, 3'h0, 8'h7F);
		rd(CTRL, 8'h1C);
		wr(0, 3'h0, 8'h00);
		wr(0, 3'h0, 8'h9C);
		rd(CTRL, 8'h9C);
		wr(1, 3'h6, 8'h01);
		rd(CTRL, 8'h9C);
		chk(ctrl, 8'h9C);
		ext_code_in = 1'b1;
		u_i2cc_bus_model.start_cond();
		u_i2cc_bus_model.send_byte(8'hA4);
		cyc(10);
		chk(scl_oe, 1'b1);
		chk(flags_out.extension_code_flag, 1'b1);
		wr(1, 3'h5, 8'h01);
		cyc(3);
		chk(scl_oe, 1'b0);
		rd(CTRL, 8'h9C);
		u_i2cc_bus_model.send_byte(8'h5A);
		cyc(10);
		chk(scl_oe, 1'b1);
		shift_write_in = 1'b1;
		cyc(1);
		shift_write_in = 1'b0;
		cyc(2);
		chk(scl_oe, 1'b0);
		u_i2cc_bus_model.send_byte(8'hC3);
		cyc(10);
		chk(scl_oe, 1'b1);
		wr(1, 3'h6, 8'h01);
		cyc(3);
		chk({scl_oe, sda_oe}, 2'h0);
		chk(flags_out[9:4], 6'h00);
		ext_code_in = 1'b0;
		u_i2cc_bus_model.send_byte(8'h33);
		cyc(10);
		chk(scl_oe, 1'b0);
		k = n_irq;
		u_i2cc_bus_model.stop_cond();
		cyc(8);
		chk(16'(n_irq), 16'(k + 1));
		wr(0, 3'h0, 8'h00);
		cyc(2);
		chk(flags_out, 16'h0000);
		wr(1, 3'h3, 8'h01);
		wr(1, 3'h7, 8'h01);
		rd(CTRL, 8'h88);
		wr(1, 3'h6, 8'h01);
		k = n_irq;
		u_i2cc_bus_model.start_cond();
		u_i2cc_bus_model.stop_cond();
		cyc(8);
		chk(16'(n_irq), 16'(k));
		wr(0, 3'h0, 8'h00);
		u_i2cc_bus_model.set_data(1'b1);
		wr(0, 3'h0, 8'h80);
		cyc(6);
		chk(flags_out.start_seen_flag, 1'b1);
		wr(1, 3'h6, 8'h01);
		cyc(3);
		chk(flags_out.start_seen_flag, 1'b0);
		u_i2cc_bus_model.set_data(1'b0);
		cyc(6);
		tx_dir_in = 1'b1;
		tx_bit_in = 1'b0;
		addr_match_in = 1'b1;
		wr(1, 3'h0, 8'h01);
		chk(flags_out.master_state_flag, 1'b1);
		u_i2cc_bus_model.start_cond();
		u_i2cc_bus_model.send_byte(8'hA5);
		cyc(10);
		chk({scl_oe, sda_oe, flags_out.transmit_direction_flag}, 3'h7);
		wr(1, 3'h5, 8'h01);
		cyc(3);
		chk({scl_oe, sda_oe, flags_out.transmit_direction_flag}, 3'h0);
		stop_test();
	end

	// Sequence needs about 4 us; ample margin
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
endmodule : i2cc_bus_control_tb_top
`default_nettype wire
